// >>> core/digit_shifter.sv
// bcd digit accumulator shifting new digits in at the low end
`timescale 1ns/1ps
`default_nettype none
module digit_shifter #(
  parameter int DIGITS = 6
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clear_i,
  input wire logic shift_i,
  input wire logic [3:0] digit_i,
  output logic [4*DIGITS-1:0] value_o,
  output logic [3:0] count_o
);
  if (DIGITS < 2 || DIGITS > 15) begin : g_bad_digits
    $error("digit_shifter: DIGITS out of range");
  end
  typedef struct packed {
    logic [4*DIGITS-1:0] value;
    logic [3:0] count;
  } shf_state_t;
  shf_state_t st_r;
  shf_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (clear_i) begin
      st_nxt.value = '0;
      st_nxt.count = 4'h0;
    end else if (shift_i) begin
      // keep only the newest digits, right aligned
      st_nxt.value = {st_r.value[4*DIGITS-5:0], digit_i};
      if (st_r.count != 4'hF) begin
        st_nxt.count = st_r.count + 4'h1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign value_o = st_r.value;
  assign count_o = st_r.count;
endmodule : digit_shifter
`default_nettype wire

// >>> core/interval_aligner.sv
// aligns interval digits on the decimal point and clamps to dwell
`timescale 1ns/1ps
`default_nettype none
module interval_aligner (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clear_i,
  input wire logic digit_i,
  input wire logic point_i,
  input wire logic [3:0] value_i,
  input wire logic [23:0] dwell_bcd_i,
  output logic [23:0] interval_o
);
  import scan_cmd_pkg::*;
  typedef struct packed {
    logic [11:0] int_part;
    logic [11:0] frac_part;
    logic [1:0] frac_cnt;
    logic seen_point;
  } aln_state_t;
  aln_state_t st_r;
  aln_state_t st_nxt;
  logic [23:0] joined;
  always_comb begin
    st_nxt = st_r;
    if (clear_i) begin
      st_nxt = '0;
    end else if (point_i) begin
      st_nxt.seen_point = 1'b1;
    end else if (digit_i) begin
      if (!st_r.seen_point) begin
        st_nxt.int_part = {st_r.int_part[7:0], value_i};
      end else if (st_r.frac_cnt != 2'(INTV_FRAC_DIGITS)) begin
        // fill fractional digits from the point rightwards
        unique case (st_r.frac_cnt)
          2'h0: st_nxt.frac_part[11:8] = value_i;
          2'h1: st_nxt.frac_part[7:4] = value_i;
          default: st_nxt.frac_part[3:0] = value_i;
        endcase
        st_nxt.frac_cnt = st_r.frac_cnt + 2'h1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign joined = {st_r.int_part, st_r.frac_part};
  assign interval_o = (joined > dwell_bcd_i) ? dwell_bcd_i : joined;
endmodule : interval_aligner
`default_nettype wire

// >>> core/scan_cmd_pkg.sv
// shared types and constants of the scanner command parser
package scan_cmd_pkg;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_EXEC = 8'h58;
  localparam logic [7:0] CH_TRIG = 8'h54;
  localparam logic [7:0] CH_TIME = 8'h53;
  localparam logic [7:0] CH_DATE = 8'h56;
  localparam logic [7:0] CH_INTV = 8'h57;
  localparam logic [7:0] CH_DISP = 8'h44;
  localparam int TIME_DIGITS = 6;
  localparam int DATE_DIGITS = 4;
  localparam int INTV_INT_DIGITS = 3;
  localparam int INTV_FRAC_DIGITS = 3;
  localparam int INTV_DIGITS = 6;
  localparam logic [23:0] TIME_RESET = 24'h000000;
  localparam logic [15:0] DATE_RESET = 16'h0101;
  localparam logic [23:0] INTV_RESET = 24'h001000;
  localparam logic [1:0] DISP_RESET = 2'h0;
  localparam logic [2:0] TRIG_RESET = 3'h0;

  typedef enum logic [2:0] {
    begin_on_talk_addressed,
    halt_on_talk_addressed,
    begin_on_group_execute,
    halt_on_group_execute,
    begin_on_execute_char,
    halt_on_execute_char,
    begin_on_external_input,
    halt_on_external_input
  } trig_mode_t;

  typedef enum logic [1:0] {
    show_channel_value,
    show_interval_value,
    show_clock_value,
    show_calendar_value
  } disp_sel_t;

  typedef struct packed {
    logic [23:0] clock_bcd;
    logic [15:0] calendar_bcd;
    logic [23:0] interval_bcd;
  } settings_t;

  typedef struct packed {
    logic talk_addressed;
    logic group_execute;
    logic external_input;
  } stimulus_t;
endpackage : scan_cmd_pkg

// >>> core/scan_trigger_time_cmd_parser.sv
// command parser for trigger mode, time, date and interval commands
`timescale 1ns/1ps
`default_nettype none
module scan_trigger_time_cmd_parser (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic char_valid_i,
  input wire logic [7:0] char_i,
  input wire scan_cmd_pkg::stimulus_t stim_i,
  input wire logic ext_trigger_pin_i,
  input wire logic step_mode_i,
  input wire logic matrix_mode_i,
  input wire logic scan_running_i,
  input wire logic [23:0] dwell_bcd_i,
  output scan_cmd_pkg::settings_t settings_o,
  output scan_cmd_pkg::trig_mode_t trig_mode_o,
  output scan_cmd_pkg::disp_sel_t disp_sel_o,
  output logic [23:0] display_digits_o,
  output logic start_o,
  output logic stop_o,
  output logic step_o,
  output logic halt_scan_o,
  output logic recall_show_o,
  output logic buffer_advance_o,
  output logic illegal_option_error_o,
  output logic clock_load_o,
  output logic calendar_load_o
);
  import scan_cmd_pkg::*;

  typedef enum logic [2:0] {
    cmd_none,
    cmd_trig,
    cmd_time,
    cmd_date,
    cmd_intv,
    cmd_disp
  } cmd_t;

  typedef struct packed {
    logic [1:0] ext_sync;
    logic ext_prev;
    cmd_t cur;
    logic got_cmd;
    logic [2:0] pend_trig;
    logic pend_trig_ok;
    logic [1:0] pend_disp;
    logic pend_disp_ok;
    logic [23:0] time_val;
    logic time_ok;
    logic [15:0] date_val;
    logic date_ok;
    logic [3:0] date_cnt;
    logic [23:0] intv_val;
    logic intv_ok;
    trig_mode_t trig;
    disp_sel_t disp;
    settings_t set;
    logic recall;
    logic start;
    logic stop;
    logic step;
    logic halt;
    logic recall_pulse;
    logic advance;
    logic err;
    logic clk_load;
    logic cal_load;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= CH_ZERO) && (c <= CH_NINE);
  endfunction : is_digit

  function automatic logic is_letter(input logic [7:0] c);
    return (c >= 8'h41) && (c <= 8'h5A);
  endfunction : is_letter

  logic in_digit;
  logic in_colon;
  logic in_point;
  logic in_letter;
  logic in_exec;
  logic [3:0] dval;
  logic acc_clear;
  logic time_shift;
  logic date_shift;
  logic [23:0] time_acc;
  logic [3:0] time_cnt;
  logic [15:0] date_acc;
  logic [3:0] date_cnt;
  logic [23:0] intv_acc;
  logic ext_rise;
  logic fire;
  logic fire_start;
  logic [3:0] use_cnt;
  logic [15:0] use_date;

  assign in_digit = char_valid_i && is_digit(char_i);
  assign in_colon = char_valid_i && (char_i == CH_COLON);
  assign in_point = char_valid_i && (char_i == CH_DOT);
  assign in_exec = char_valid_i && (char_i == CH_EXEC);
  assign in_letter = char_valid_i && is_letter(char_i) && !in_exec;
  assign dval = char_i[3:0];
  assign acc_clear = in_letter;
  // digits shift in from seconds end
  assign time_shift = in_digit && (st_r.cur == cmd_time);
  assign date_shift = in_digit && (st_r.cur == cmd_date);
  assign ext_rise = st_r.ext_sync[1] && !st_r.ext_prev;
  assign use_cnt = (st_r.cur == cmd_date) ? date_cnt : st_r.date_cnt;
  assign use_date = (st_r.cur == cmd_date) ? date_acc : st_r.date_val;

  digit_shifter #(.DIGITS(TIME_DIGITS)) u_time (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(acc_clear),
    .shift_i(time_shift),
    .digit_i(dval),
    .value_o(time_acc),
    .count_o(time_cnt)
  );

  digit_shifter #(.DIGITS(DATE_DIGITS)) u_date (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(acc_clear),
    .shift_i(date_shift),
    .digit_i(dval),
    .value_o(date_acc),
    .count_o(date_cnt)
  );

  interval_aligner u_intv (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(acc_clear),
    .digit_i(in_digit && (st_r.cur == cmd_intv)),
    .point_i(in_point && (st_r.cur == cmd_intv)),
    .value_i(dval),
    .dwell_bcd_i(dwell_bcd_i),
    .interval_o(intv_acc)
  );

  // trigger source match for the active mode
  always_comb begin
    fire = 1'b0;
    unique case (st_r.trig)
      begin_on_talk_addressed, halt_on_talk_addressed:
        fire = stim_i.talk_addressed;
      begin_on_group_execute, halt_on_group_execute:
        fire = stim_i.group_execute;
      begin_on_execute_char, halt_on_execute_char:
        fire = in_exec;
      begin_on_external_input, halt_on_external_input:
        fire = ext_rise;
    endcase
  end
  assign fire_start = !st_r.trig[0];

  always_comb begin
    st_nxt = st_r;
    st_nxt.ext_sync = {st_r.ext_sync[0], ext_trigger_pin_i};
    st_nxt.ext_prev = st_r.ext_sync[1];
    st_nxt.start = 1'b0;
    st_nxt.stop = 1'b0;
    st_nxt.step = 1'b0;
    st_nxt.halt = 1'b0;
    st_nxt.recall_pulse = 1'b0;
    st_nxt.advance = 1'b0;
    st_nxt.err = 1'b0;
    st_nxt.clk_load = 1'b0;
    st_nxt.cal_load = 1'b0;
    if (in_letter) begin
      st_nxt.got_cmd = 1'b1;
      unique case (char_i)
        CH_TRIG: st_nxt.cur = cmd_trig;
        CH_TIME: st_nxt.cur = cmd_time;
        CH_DATE: st_nxt.cur = cmd_date;
        CH_INTV: st_nxt.cur = cmd_intv;
        CH_DISP: st_nxt.cur = cmd_disp;
        default: st_nxt.cur = cmd_none;
      endcase
      // latch previous field before switching
      if (st_r.cur == cmd_time) begin
        st_nxt.time_val = time_acc;
        st_nxt.time_ok = 1'b1;
      end
      if (st_r.cur == cmd_date) begin
        st_nxt.date_val = date_acc;
        st_nxt.date_cnt = date_cnt;
        st_nxt.date_ok = 1'b1;
      end
      if (st_r.cur == cmd_intv) begin
        st_nxt.intv_val = intv_acc;
        st_nxt.intv_ok = 1'b1;
      end
    end else if (in_digit && st_r.cur == cmd_trig && dval < 4'h8) begin
      st_nxt.pend_trig = dval[2:0];
      st_nxt.pend_trig_ok = 1'b1;
    end else if (in_digit && st_r.cur == cmd_disp && dval < 4'h4) begin
      st_nxt.pend_disp = dval[1:0];
      st_nxt.pend_disp_ok = 1'b1;
    end
    if (in_colon) begin
      st_nxt.cur = st_r.cur;
    end
    if (in_exec) begin
      st_nxt.cur = cmd_none;
      st_nxt.got_cmd = 1'b0;
      st_nxt.pend_trig_ok = 1'b0;
      st_nxt.pend_disp_ok = 1'b0;
      st_nxt.time_ok = 1'b0;
      st_nxt.date_ok = 1'b0;
      st_nxt.intv_ok = 1'b0;
      if ((st_r.got_cmd || st_r.cur != cmd_none) && scan_running_i) begin
        st_nxt.halt = 1'b1;
      end
      if (st_r.pend_trig_ok) begin
        st_nxt.trig = trig_mode_t'(st_r.pend_trig);
      end
      if (st_r.pend_disp_ok) begin
        st_nxt.disp = disp_sel_t'(st_r.pend_disp);
      end
      if (st_r.time_ok || st_r.cur == cmd_time) begin
        st_nxt.set.clock_bcd = (st_r.cur == cmd_time) ? time_acc
                                                      : st_r.time_val;
        st_nxt.clk_load = 1'b1;
      end
      if (st_r.intv_ok || st_r.cur == cmd_intv) begin
        st_nxt.set.interval_bcd = (st_r.cur == cmd_intv) ? intv_acc
                                                         : st_r.intv_val;
      end
      if (st_r.date_ok || st_r.cur == cmd_date) begin
        // too few digits: error, keep date
        if (use_cnt < 4'h3) begin
          st_nxt.err = 1'b1;
        end else begin
          st_nxt.set.calendar_bcd = (use_cnt == 4'h3) ?
                                    {4'h0, use_date[11:0]} : use_date;
          st_nxt.cal_load = 1'b1;
        end
      end
    end
    if (fire) begin
      if (matrix_mode_i) begin
        if (!st_r.recall) begin
          st_nxt.recall = 1'b1;
          st_nxt.recall_pulse = 1'b1;
        end else begin
          st_nxt.advance = 1'b1;
        end
      end else if (step_mode_i) begin
        st_nxt.step = 1'b1;
      end else if (fire_start) begin
        st_nxt.start = 1'b1;
      end else begin
        st_nxt.stop = 1'b1;
      end
    end
    if (!matrix_mode_i) begin
      st_nxt.recall = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.cur <= cmd_none;
      st_r.trig <= trig_mode_t'(TRIG_RESET);
      st_r.disp <= disp_sel_t'(DISP_RESET);
      st_r.set <= '{TIME_RESET, DATE_RESET, INTV_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign settings_o = st_r.set;
  assign trig_mode_o = st_r.trig;
  assign disp_sel_o = st_r.disp;
  assign display_digits_o = (st_r.disp == show_interval_value) ?
                            st_r.set.interval_bcd :
                            (st_r.disp == show_clock_value) ?
                            st_r.set.clock_bcd :
                            (st_r.disp == show_calendar_value) ?
                            {8'h00, st_r.set.calendar_bcd} : 24'h000000;
  assign start_o = st_r.start;
  assign stop_o = st_r.stop;
  assign step_o = st_r.step;
  assign halt_scan_o = st_r.halt;
  assign recall_show_o = st_r.recall;
  assign buffer_advance_o = st_r.advance;
  assign illegal_option_error_o = st_r.err;
  assign clock_load_o = st_r.clk_load;
  assign calendar_load_o = st_r.cal_load;
endmodule : scan_trigger_time_cmd_parser
`default_nettype wire

// >>> verif/bus_ctrl_model.sv
// bus controller model sending command bytes and triggers
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  input wire logic clk_i,
  output logic char_valid_o,
  output logic [7:0] char_o,
  output scan_cmd_pkg::stimulus_t stim_o
);
  import scan_cmd_pkg::*;
  initial begin
    char_valid_o = 1'b0;
    char_o = 8'h00;
    stim_o = '0;
  end
  // one byte per cycle, back to back
  task put(input logic [7:0] c);
    @(negedge clk_i);
    char_valid_o = 1'b1;
    char_o = c;
  endtask : put
  // released bus shows inverted byte
  task rel();
    @(negedge clk_i);
    char_valid_o = 1'b0;
    char_o = ~char_o;
  endtask : rel
  task send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      put(s[i]);
    end
    rel();
  endtask : send
  // one-cycle talk or trigger pulse
  task pulse(input logic [2:0] which);
    @(negedge clk_i);
    stim_o = stimulus_t'(which);
    @(negedge clk_i);
    stim_o = '0;
  endtask : pulse
endmodule : bus_ctrl_model
`default_nettype wire

// >>> verif/scan_trigger_time_cmd_parser_asserts.sv
// port checker for the scanner command parser
`timescale 1ns/1ps
`default_nettype none
module scan_trigger_time_cmd_parser_asserts (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic char_valid_i,
  input wire logic [7:0] char_i,
  input wire scan_cmd_pkg::stimulus_t stim_i,
  input wire logic ext_trigger_pin_i,
  input wire logic step_mode_i,
  input wire logic matrix_mode_i,
  input wire logic scan_running_i,
  input wire logic [23:0] dwell_bcd_i,
  input wire scan_cmd_pkg::settings_t settings_o,
  input wire scan_cmd_pkg::trig_mode_t trig_mode_o,
  input wire scan_cmd_pkg::disp_sel_t disp_sel_o,
  input wire logic [23:0] display_digits_o,
  input wire logic start_o,
  input wire logic stop_o,
  input wire logic step_o,
  input wire logic halt_scan_o,
  input wire logic recall_show_o,
  input wire logic buffer_advance_o,
  input wire logic illegal_option_error_o,
  input wire logic clock_load_o,
  input wire logic calendar_load_o
);
  import scan_cmd_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic x_now;
  assign x_now = char_valid_i && char_i == CH_EXEC;
  AST_GE_START: assert property (
    trig_mode_o == begin_on_group_execute && stim_i.group_execute
    && !step_mode_i && !matrix_mode_i |=> start_o)
    else $error("no start after trigger");
  AST_ONE_WAY: assert property (!(start_o && stop_o))
    else $error("start and stop together");
  AST_STEP: assert property (
    step_mode_i && !matrix_mode_i && stim_i.group_execute
    && trig_mode_o == begin_on_group_execute |=> step_o && !start_o)
    else $error("step missing");
  AST_HALT: assert property (
    halt_scan_o |-> $past(x_now && scan_running_i))
    else $error("halt without command");
  AST_LOAD_ON_X: assert property (
    clock_load_o || calendar_load_o |-> $past(x_now))
    else $error("load without execute");
  AST_ERR_KEEP: assert property (
    illegal_option_error_o |-> !calendar_load_o
    && $stable(settings_o.calendar_bcd))
    else $error("date changed on error");
  AST_MODE_ON_X: assert property (
    !$stable(trig_mode_o) |-> $past(x_now))
    else $error("mode changed without execute");
  AST_CLAMP: assert property (
    !$stable(settings_o.interval_bcd)
    |-> settings_o.interval_bcd <= dwell_bcd_i)
    else $error("interval above dwell");
  AST_SHOW_INTV: assert property (
    disp_sel_o == show_interval_value
    |-> display_digits_o == settings_o.interval_bcd)
    else $error("interval display wrong");
  AST_ADVANCE: assert property (
    buffer_advance_o |-> $past(recall_show_o))
    else $error("advance without recall");
endmodule : scan_trigger_time_cmd_parser_asserts
bind scan_trigger_time_cmd_parser scan_trigger_time_cmd_parser_asserts
  i_chk (.*);
`default_nettype wire

// >>> verif/scan_trigger_time_cmd_parser_tb.sv
// self-checking bench for the scanner command parser
`timescale 1ns/1ps
`default_nettype none
module scan_trigger_time_cmd_parser_tb;
  import scan_cmd_pkg::*;
  logic clk_i;
  logic sys_rst_i;
  logic ext_pin;
  logic step_m;
  logic matrix_m;
  logic running;
  logic [23:0] dwell;
  logic cv;
  logic [7:0] ch;
  stimulus_t stim;
  settings_t set_w;
  trig_mode_t trig_w;
  disp_sel_t disp_w;
  logic [23:0] digits_w;
  logic start_w, stop_w, step_w, halt_w, recall_w, adv_w, err_w;
  logic cld_w, calld_w;
  integer n_start, n_stop, n_step, n_halt, n_adv, n_err, n_cld, n_calld;
  int miscompares = 0;
  int tests_run = 0;
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  bus_ctrl_model i_bus (.clk_i(clk_i), .char_valid_o(cv), .char_o(ch),
    .stim_o(stim));
  scan_trigger_time_cmd_parser i_dut (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .char_valid_i(cv), .char_i(ch), .stim_i(stim),
    .ext_trigger_pin_i(ext_pin), .step_mode_i(step_m),
    .matrix_mode_i(matrix_m), .scan_running_i(running),
    .dwell_bcd_i(dwell), .settings_o(set_w), .trig_mode_o(trig_w),
    .disp_sel_o(disp_w), .display_digits_o(digits_w), .start_o(start_w),
    .stop_o(stop_w), .step_o(step_w), .halt_scan_o(halt_w),
    .recall_show_o(recall_w), .buffer_advance_o(adv_w),
    .illegal_option_error_o(err_w), .clock_load_o(cld_w),
    .calendar_load_o(calld_w));
  always @(posedge clk_i) begin
    n_start = n_start + start_w;
    n_stop = n_stop + stop_w;
    n_step = n_step + step_w;
    n_halt = n_halt + halt_w;
    n_adv = n_adv + adv_w;
    n_err = n_err + err_w;
    n_cld = n_cld + cld_w;
    n_calld = n_calld + calld_w;
  end
  task clr();
    {n_start, n_stop, n_step, n_halt, n_adv, n_err, n_cld, n_calld} = '0;
  endtask : clr
  task pause(input int k);
    repeat (k) @(negedge clk_i);
  endtask : pause
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task cmd(input string s);
    i_bus.send(s);
    pause(3);
  endtask : cmd
  task t_reset();
    chk(set_w.clock_bcd, 24'h000000);
    chk(24'(set_w.calendar_bcd), 24'h000101);
    chk(set_w.interval_bcd, 24'h001000);
    chk(24'(trig_w), 24'h000000);
  endtask : t_reset
  task t_time();
    clr();
    cmd("S12:34:56X");
    chk(set_w.clock_bcd, 24'h123456);
    cmd("S654321X");
    chk(set_w.clock_bcd, 24'h654321);
    cmd("S1234X");
    chk(set_w.clock_bcd, 24'h001234);
    cmd("S17XD2X");
    chk(set_w.clock_bcd, 24'h000017);
    chk(digits_w, 24'h000017);
    chk(24'(n_cld), 24'h000004);
  endtask : t_time
  task t_date();
    clr();
    cmd("V12:07X");
    chk(24'(set_w.calendar_bcd), 24'h001207);
    cmd("V0712X");
    chk(24'(set_w.calendar_bcd), 24'h000712);
    cmd("V123X");
    chk(24'(set_w.calendar_bcd), 24'h000123);
    chk(24'(n_calld), 24'h000003);
    clr();
    cmd("V12XD3X");
    chk(24'(n_err), 24'h000001);
    chk(24'(n_calld), 24'h000000);
    chk(24'(set_w.calendar_bcd), 24'h000123);
    chk(24'(disp_w), 24'(show_calendar_value));
  endtask : t_date
  task t_intv();
    cmd("W003.00X");
    chk(set_w.interval_bcd, 24'h003000);
    cmd("W.5XD1X");
    chk(set_w.interval_bcd, 24'h000500);
    chk(digits_w, 24'h000500);
    dwell = 24'h002500;
    cmd("W3X");
    chk(set_w.interval_bcd, 24'h002500);
    dwell = 24'h999999;
  endtask : t_intv
  task t_trig();
    for (int m = 0; m < 8; m++) begin
      i_bus.put(CH_TRIG);
      i_bus.put(CH_ZERO + 8'(m));
      i_bus.put(CH_EXEC);
      i_bus.rel();
      pause(4);
      chk(24'(trig_w), 24'(m));
      clr();
      i_bus.pulse(3'h4);
      i_bus.pulse(3'h2);
      ext_pin = 1'b1;
      pause(4);
      ext_pin = 1'b0;
      cmd("X");
      chk(24'(n_start), 24'(m % 2 == 0));
      chk(24'(n_stop), 24'(m % 2));
    end
  endtask : t_trig
  task t_step_matrix();
    cmd("T2X");
    cmd("T9X");
    chk(24'(trig_w), 24'h000002);
    step_m = 1'b1;
    clr();
    i_bus.pulse(3'h2);
    i_bus.pulse(3'h2);
    pause(3);
    chk(24'(n_step), 24'h000002);
    chk(24'(n_start), 24'h000000);
    step_m = 1'b0;
    matrix_m = 1'b1;
    i_bus.pulse(3'h2);
    pause(3);
    chk(24'(recall_w), 24'h000001);
    chk(24'(n_adv), 24'h000000);
    i_bus.pulse(3'h2);
    pause(3);
    chk(24'(n_adv), 24'h000001);
    matrix_m = 1'b0;
    pause(3);
  endtask : t_step_matrix
  task t_halt();
    running = 1'b1;
    clr();
    cmd("D2X");
    chk(24'(n_halt), 24'h000001);
    running = 1'b0;
  endtask : t_halt
  task tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    sys_rst_i = 1'b1;
    ext_pin = 1'b0;
    step_m = 1'b0;
    matrix_m = 1'b0;
    running = 1'b0;
    dwell = 24'h999999;
    clr();
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    pause(1);
    t_reset();
    t_time();
    t_date();
    t_intv();
    t_trig();
    t_step_matrix();
    t_halt();
    tally_and_finish();
  end
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end
endmodule : scan_trigger_time_cmd_parser_tb
`default_nettype wire
